// file: core/ssp_port.sv
// sync serial port: wishbone registers, byte shifter, interrupt logic
//
// Function
// - A received byte lands in bits 7..0 of the receive register.
// - Two transmit registers each hold a byte to shift out.
// - The serial clock is the processor clock over 2, 4, 8 or 16.
// - Enable zero follows its control bit; enable one follows its bit only while bit zero is clear.
// - With both control bits set only enable zero goes high.
// - Control and status read zero after reset.
// - Reading receive or writing transmit while busy sets the error flag.
// - The error flag clears while both enable bits are zero.
// - Transfer complete sets on the rising edge that ends bit 7.
// - Complete clears on rx read, tx write, status read or no enable.
// - A set of complete wins over a clearing status read.
// - Busy is high from the starting transmit write until the received byte loads, three cycles after the eighth rising edge.
// - Status is read only and its upper bits read zero.
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_port (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic peripheral_enable_zero,
    output logic peripheral_enable_one,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] control;
        logic [7:0] tx_zero;
        logic [7:0] tx_one;
        logic [7:0] rx;
        logic [7:0] shift;
        logic [3:0] bit_count;
        logic [2:0] rise_pipe;
        logic [7:0] rx_shift;
        logic [3:0] rx_count;
        ssp_pkg::ssp_state_t state;
        logic busy;
        logic done;
        logic err;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [1:0] din_sync;
        logic sclk;
        logic dout;
        logic doe;
        logic en0;
        logic en1;
        logic irq;
        logic ack;
        logic berr;
        logic [31:0] rdata;
    } ssp_regs_t;

    ssp_regs_t r;
    ssp_regs_t next_r;
    logic half_tick;
    logic req;
    logic wr;
    logic rd;
    logic hit_status;
    logic hit_ctrl;
    logic hit_tx0;
    logic hit_tx1;
    logic hit_rx;
    logic hit_irqs;
    logic hit_irqm;
    logic mapped;
    logic set_done;
    logic set_err;
    logic no_enable;
    logic [15:0] status_word;
    logic [31:0] rd_word;

    ssp_clock_divider u_div (
        .mclk(mclk),
        .reset(reset),
        .run(r.state != ssp_pkg::SSP_IDLE),
        .div_sel(r.control[`SSP_DIV_HI:`SSP_DIV_LO]),
        .half_tick(half_tick)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_r = r;
        // new request only when no ack is outstanding
        req = wb_cyc_i && wb_stb_i && !r.ack && !r.berr;
        wr = req && wb_we_i && wb_sel_i[0];
        rd = req && !wb_we_i;
        hit_status = wb_adr_i == `SSP_OFS_STATUS;
        hit_ctrl = wb_adr_i == `SSP_OFS_CONTROL;
        hit_tx0 = wb_adr_i == `SSP_OFS_TX_ZERO;
        hit_tx1 = wb_adr_i == `SSP_OFS_TX_ONE;
        hit_rx = wb_adr_i == `SSP_OFS_RX;
        hit_irqs = wb_adr_i == `SSP_OFS_IRQ_STATUS;
        hit_irqm = wb_adr_i == `SSP_OFS_IRQ_MASK;
        mapped = hit_status || hit_ctrl || hit_tx0 || hit_tx1 || hit_rx
            || hit_irqs || hit_irqm;
        set_done = 1'b0;
        no_enable = !r.control[`SSP_BIT_EN0] && !r.control[`SSP_BIT_EN1];
        status_word = 16'h0000;
        status_word[`SSP_BIT_BUSY] = r.busy;
        status_word[`SSP_BIT_DONE] = r.done;
        status_word[`SSP_BIT_ERR] = r.err;
        rd_word = 32'h00000000;

        next_r.din_sync = {r.din_sync[0], serial_data_in};
        next_r.rise_pipe = {r.rise_pipe[1:0], 1'b0};
        next_r.ack = req && mapped;
        next_r.berr = req && !mapped;

        // serial engine, mode 0 style: data out on falling, sampled rising
        if (half_tick) begin
            case (r.state)
                ssp_pkg::SSP_LOW: begin
                    next_r.sclk = 1'b1;
                    next_r.state = ssp_pkg::SSP_HIGH;
                    next_r.shift = {r.shift[6:0], 1'b0};
                    next_r.rise_pipe[0] = 1'b1;
                    next_r.bit_count = r.bit_count + 4'h1;
                    if (r.bit_count == `SSP_BITS_PER_BYTE - 4'h1) begin
                        set_done = 1'b1;
                    end
                end
                ssp_pkg::SSP_HIGH: begin
                    next_r.sclk = 1'b0;
                    if (r.bit_count == `SSP_BITS_PER_BYTE) begin
                        next_r.state = ssp_pkg::SSP_IDLE;
                        next_r.doe = 1'b0;
                    end else begin
                        next_r.state = ssp_pkg::SSP_LOW;
                        next_r.dout = r.shift[7];
                    end
                end
                default: begin
                    next_r.state = ssp_pkg::SSP_IDLE;
                end
            endcase
        end

        // pin sync lags: take each bit three cycles after its rise
        if (r.rise_pipe[2]) begin
            next_r.rx_shift = {r.rx_shift[6:0], r.din_sync[1]};
            next_r.rx_count = r.rx_count + 4'h1;
            if (r.rx_count == `SSP_BITS_PER_BYTE - 4'h1) begin
                next_r.rx = {r.rx_shift[6:0], r.din_sync[1]};
                next_r.busy = 1'b0;
            end
        end

        set_err = r.busy && ((rd && hit_rx)
            || (wr && (hit_tx0 || hit_tx1)));

        // register writes
        if (wr && hit_ctrl) begin
            next_r.control = {10'h000, wb_dat_i[5:4], 2'h0,
                wb_dat_i[1:0]};
        end
        if (wr && hit_irqm) begin
            next_r.irq_mask = wb_dat_i[1:0];
        end
        if (wr && (hit_tx0 || hit_tx1) && !r.busy) begin
            if (hit_tx0) begin
                next_r.tx_zero = wb_dat_i[7:0];
            end else begin
                next_r.tx_one = wb_dat_i[7:0];
            end
            // start only with a peripheral selected
            if (!no_enable) begin
                next_r.busy = 1'b1;
                next_r.state = ssp_pkg::SSP_LOW;
                next_r.bit_count = 4'h0;
                next_r.rx_count = 4'h0;
                next_r.shift = wb_dat_i[7:0];
                next_r.dout = wb_dat_i[7];
                next_r.doe = 1'b1;
                next_r.sclk = 1'b0;
            end
        end

        // flags: done clears first, then sets so the set wins; for err the clear on no enable wins over the set
        if ((rd && (hit_rx || hit_status)) || (wr && (hit_tx0 || hit_tx1))
            || no_enable) begin
            next_r.done = 1'b0;
        end
        if (set_done) begin
            next_r.done = 1'b1;
        end
        if (no_enable) begin
            next_r.err = 1'b0;
        end else if (set_err) begin
            next_r.err = 1'b1;
        end

        // interrupt status, write one to clear, set wins
        if (wr && hit_irqs) begin
            next_r.irq_status = r.irq_status & ~wb_dat_i[1:0];
        end
        if (set_done) begin
            next_r.irq_status[`SSP_IRQ_DONE] = 1'b1;
        end
        if (set_err && !no_enable) begin
            next_r.irq_status[`SSP_IRQ_ERR] = 1'b1;
        end
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);

        // enables follow control, zero has priority
        next_r.en0 = next_r.control[`SSP_BIT_EN0];
        next_r.en1 = next_r.control[`SSP_BIT_EN1]
            && !next_r.control[`SSP_BIT_EN0];

        // read data
        if (hit_status) begin
            rd_word[15:0] = status_word;
        end else if (hit_ctrl) begin
            rd_word[15:0] = r.control;
        end else if (hit_tx0) begin
            rd_word[7:0] = r.tx_zero;
        end else if (hit_tx1) begin
            rd_word[7:0] = r.tx_one;
        end else if (hit_rx) begin
            rd_word[7:0] = r.rx;
        end else if (hit_irqs) begin
            rd_word[1:0] = r.irq_status;
        end else if (hit_irqm) begin
            rd_word[1:0] = r.irq_mask;
        end
        next_r.rdata = rd ? rd_word : 32'h00000000;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            r.control <= `SSP_CTRL_RESET;
            r.state <= ssp_pkg::SSP_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign wb_err_o = r.berr;
    assign serial_clock = r.sclk;
    assign serial_data_out = r.dout;
    assign serial_data_oe = r.doe;
    assign peripheral_enable_zero = r.en0;
    assign peripheral_enable_one = r.en1;
    assign irq = r.irq;
endmodule : ssp_port

// file: core/ssp_cfg.svh
// constants of the sync serial port: offsets, fields, reset values
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_OFS_STATUS 8'h10
`define SSP_OFS_CONTROL 8'h12
`define SSP_OFS_TX_ZERO 8'h14
`define SSP_OFS_TX_ONE 8'h16
`define SSP_OFS_RX 8'h18
`define SSP_OFS_IRQ_STATUS 8'h1C
`define SSP_OFS_IRQ_MASK 8'h20
`define SSP_CTRL_RESET 16'h0000
`define SSP_STATUS_RESET 16'h0000
`define SSP_BIT_EN0 0
`define SSP_BIT_EN1 1
`define SSP_DIV_LO 4
`define SSP_DIV_HI 5
`define SSP_BIT_BUSY 0
`define SSP_BIT_DONE 1
`define SSP_BIT_ERR 2
`define SSP_BITS_PER_BYTE 4'h8
`define SSP_IRQ_DONE 0
`define SSP_IRQ_ERR 1
`endif

// file: core/ssp_pkg.sv
// types of the sync serial port
package ssp_pkg;
    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_LOW,
        SSP_HIGH
    } ssp_state_t;
endpackage : ssp_pkg

// file: core/ssp_clock_divider.sv
// serial clock enable divider: one-cycle pulse every 2^(div+1)/2 cycles
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_clock_divider (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic half_tick
);
    typedef struct packed {
        logic [3:0] count;
        logic tick;
    } ssp_div_t;
    ssp_div_t r;
    ssp_div_t next_r;
    logic [3:0] limit;

    always_comb begin
        // half period of the serial clock, in processor clocks, minus one
        limit = 4'((4'h1 << div_sel) - 4'h1);
        next_r = r;
        next_r.tick = 1'b0;
        if (!run) begin
            next_r.count = 4'h0;
        end else if (r.count >= limit) begin
            next_r.count = 4'h0;
            next_r.tick = 1'b1;
        end else begin
            next_r.count = r.count + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign half_tick = r.tick;
endmodule : ssp_clock_divider

// file: tb/ssp_periph.sv
// external serial peripheral model
`timescale 1ns/1ps
module ssp_periph (
    input wire logic serial_clock,
    input wire logic serial_data_out,
    input wire logic sel,
    input wire logic [7:0] tx_byte,
    output logic serial_data_in,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    logic last = 1'b0;
    // released line shows inverse of last bit
    assign serial_data_in = sel ? sh[7] : ~last;
    always @(posedge sel) sh = tx_byte;
    always @(posedge serial_clock) rx_byte = {rx_byte[6:0], serial_data_out};
    always @(negedge serial_clock) begin
        last = sh[7];
        sh = {sh[6:0], 1'b0};
    end
endmodule : ssp_periph

// file: tb/ssp_port_asserts.sv
// pin level checks of the sync serial port
`timescale 1ns/1ps
module ssp_port_asserts (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic serial_clock,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic peripheral_enable_zero,
    input wire logic peripheral_enable_one
);
    logic sclk_q;
    logic [3:0] rises;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    always_ff @(posedge mclk) begin
        sclk_q <= serial_clock;
        if (reset || !serial_data_oe) rises <= 4'h0;
        else if (serial_clock && !sclk_q) rises <= rises + 4'h1;
    end
    chk_one_enable: assert property (
        !(peripheral_enable_zero && peripheral_enable_one)) else $error("en");
    chk_ack_late: assert property (
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o || wb_err_o) else $error("ack");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack width");
    chk_upper_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper");
    chk_clk_idle: assert property (
        !serial_data_oe && !$past(serial_data_oe) |-> !serial_clock)
        else $error("clk idle");
    chk_data_hold: assert property (
        serial_clock && $past(serial_clock) |-> $stable(serial_data_out))
        else $error("data hold");
    chk_oe_select: assert property (
        $rose(serial_data_oe) |-> peripheral_enable_zero || peripheral_enable_one)
        else $error("oe");
    chk_eight_bits: assert property (
        $fell(serial_data_oe) |-> rises == 4'h8) else $error("bits");
endmodule : ssp_port_asserts
bind ssp_port ssp_port_asserts u_chk (.mclk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .serial_clock, .serial_data_out,
    .serial_data_oe, .peripheral_enable_zero, .peripheral_enable_one);

// file: tb/tb_sync_serial_port.sv
// self-checking bench of the sync serial port
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module tb_sync_serial_port;
    logic mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, pbyte = 8'h00, prx;
    logic [31:0] wdat = 32'h0, dat_o, rd;
    logic ack, err, sclk, sdi, sdo, oe, en0, en1, irq, bus_err;
    int failures = 0, check_count = 0;
    always #50 mclk = ~mclk;
    ssp_port u_dut (.mclk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .serial_clock(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
        .serial_data_oe(oe), .peripheral_enable_zero(en0),
        .peripheral_enable_one(en1), .irq);
    ssp_periph u_peer (.serial_clock(sclk), .serial_data_out(sdo),
        .sel(en0 | en1), .tx_byte(pbyte), .serial_data_in(sdi), .rx_byte(prx));
    // ****************
    // bus and compare
    // ****************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (!(ack || err) && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rd = dat_o;
        bus_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task t_regs;
        bus(1'b1, `SSP_OFS_STATUS, 16'hFFFF);
        bus(1'b0, `SSP_OFS_STATUS, 16'h0000);
        chk(rd, 32'h0);
        bus(1'b0, `SSP_OFS_CONTROL, 16'h0000);
        chk(rd, 32'h0);
        bus(1'b0, 8'h40, 16'h0000);
        chk({31'h0, bus_err}, 32'h1);
        $display("regs done");
    endtask : t_regs
    task t_enables;
        for (int v = 0; v < 4; v++) begin
            bus(1'b1, `SSP_OFS_CONTROL, 16'(v));
            repeat (2) @(posedge mclk);
            chk({en1, en0}, {v[1] && !v[0], v[0]});
        end
        bus(1'b1, `SSP_OFS_CONTROL, 16'h0000);
        $display("enables done");
    endtask : t_enables
    task t_xfer(input logic [1:0] div, input logic [7:0] tx,
            input logic [7:0] px, input logic [1:0] mask);
        int n;
        realtime t0;
        pbyte = px;
        bus(1'b1, `SSP_OFS_IRQ_MASK, {14'h0, mask});
        bus(1'b1, `SSP_OFS_CONTROL, {10'h0, div, 4'h1});
        bus(1'b1, div[0] ? `SSP_OFS_TX_ONE : `SSP_OFS_TX_ZERO, {8'h0, tx});
        @(posedge sclk);
        t0 = $realtime;
        @(posedge sclk);
        chk(32'(int'($realtime - t0)), 32'(200 << div));
        bus(1'b0, `SSP_OFS_STATUS, 16'h0000);
        chk(rd, 32'h1);
        bus(1'b1, `SSP_OFS_TX_ZERO, 16'h00FF);
        n = 0;
        while (oe && n < 500) begin
            @(posedge mclk);
            n++;
        end
        bus(1'b0, `SSP_OFS_STATUS, 16'h0000);
        chk(rd, 32'h6);
        bus(1'b0, `SSP_OFS_STATUS, 16'h0000);
        chk(rd, 32'h4);
        chk({24'h0, prx}, {24'h0, tx});
        bus(1'b0, `SSP_OFS_RX, 16'h0000);
        chk(rd, {24'h0, px});
        chk({31'h0, irq}, {31'h0, |mask});
        bus(1'b1, `SSP_OFS_IRQ_STATUS, 16'h0003);
        bus(1'b0, `SSP_OFS_IRQ_STATUS, 16'h0000);
        chk({rd[1:0], irq}, 3'h0);
        bus(1'b1, `SSP_OFS_CONTROL, 16'h0000);
        bus(1'b0, `SSP_OFS_STATUS, 16'h0000);
        chk(rd, 32'h0);
        $display("transfer done");
    endtask : t_xfer
    task summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_enables();
        for (int d = 0; d < 4; d++) begin
            t_xfer(2'(d), 8'hC3 ^ 8'(d), 8'h5A + 8'(d), {2{d != 2}});
        end
        summarize();
    end
endmodule : tb_sync_serial_port
